// ---- tpoc_ctrl.sv ----
// timed pulse output controller: enable register plus pin drivers
// assumes compare-match strobes are one-cycle pulses synchronous to clk_sys_in
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - eight pulse pins, driven only by this block once assigned
// - any mix of pins may be enabled; one event moves several pins
// - pins change only on the two compare-match strobes, on reset and on hardware standby
// - one 16-bit read/write enable register at the fixed address
// - byte and halfword access; each access takes four bus cycles
// - reset and hardware standby clear the enable register to zero
// - software standby leaves the enable register untouched
// - bits 15..8 enable low drive, bit 8 for pin 0
// - bits 7..0 enable high drive on the rise compare strobe
// - fall compare strobe drives low on pins with low enable
// - both strobes together on a doubly enabled pin give low
// - an enabled pin stays low until its first enabled event
module tpoc_ctrl #(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // low-power control
  input  wire logic        hw_standby_in,
  // timer channel compare strobes
  input  wire logic        rise_match_in,
  input  wire logic        fall_match_in,
  // avalon-mm register slave
  input  wire logic [31:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // pulse pins
  output logic [PIN_COUNT-1:0] pulse_out
);

  // ****************************************
  // elaboration check
  // ****************************************
  // the register holds one enable pair per pin, so at most eight pins
  if (PIN_COUNT < 1 || PIN_COUNT > tpoc_pkg::MAX_PINS) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 8");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tpoc_pkg::tpoc_bus_type     bus;
    logic [tpoc_pkg::CNT_W-1:0] cnt;
    logic                       wait_req;
    logic [31:0]                rdata;
    logic [15:0]                ctrl;
    logic [PIN_COUNT-1:0]       pins;
  } tpoc_state_type;

  localparam tpoc_state_type STATE_RESET = '{
    bus:      tpoc_pkg::BUS_IDLE,
    cnt:      '0,
    wait_req: 1'b1,
    rdata:    tpoc_pkg::RDATA_RESET,
    ctrl:     tpoc_pkg::CTRL_RESET,
    pins:     tpoc_pkg::PINS_RESET[PIN_COUNT-1:0]
  };

  tpoc_state_type       s_reg;
  tpoc_state_type       s_next;
  logic                 req;
  logic                 hit;
  logic [PIN_COUNT-1:0] high_en;
  logic [PIN_COUNT-1:0] low_en;
  logic [PIN_COUNT-1:0] pins_next;

  // ****************************************
  // decode
  // ****************************************
  // only the word address matters; byte lanes pick the half
  assign req     = avs_read_in | avs_write_in;
  assign hit     = avs_address_in[31:2] == tpoc_pkg::CTRL_ADDR[31:2];
  assign high_en = s_reg.ctrl[tpoc_pkg::HIGH_EN_LSB +: PIN_COUNT];
  assign low_en  = s_reg.ctrl[tpoc_pkg::LOW_EN_LSB +: PIN_COUNT];

  // ****************************************
  // per-pin drivers
  // ****************************************
  // each pin is set or cleared on its own, so any mix may move at once
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    always_comb begin
      // low is applied last so it wins a tie
      pins_next[i] = s_reg.pins[i];
      if (rise_match_in && high_en[i]) begin
        pins_next[i] = 1'b1;
      end
      if (fall_match_in && low_en[i]) begin
        pins_next[i] = 1'b0;
      end
    end
  end

  // ****************************************
  // next state
  // ****************************************
  // enables are read only on a strobe, so a write never moves a pin
  always_comb begin
    s_next      = s_reg;
    s_next.pins = pins_next;
    unique case (s_reg.bus)
      tpoc_pkg::BUS_IDLE: begin
        if (req) begin
          s_next.bus = tpoc_pkg::BUS_COUNT;
          s_next.cnt = tpoc_pkg::CNT_FIRST;
        end
      end
      tpoc_pkg::BUS_COUNT: begin
        // fixed length access
        if (s_reg.cnt == tpoc_pkg::CNT_LAST) begin
          s_next.bus      = tpoc_pkg::BUS_ANSWER;
          s_next.wait_req = 1'b0;
          s_next.rdata    = hit ? {16'h0000, s_reg.ctrl} : 32'h0000_0000;
        end else begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
      tpoc_pkg::BUS_ANSWER: begin
        // master samples waitrequest low here, so the write lands now
        s_next.bus      = tpoc_pkg::BUS_IDLE;
        s_next.wait_req = 1'b1;
        if (avs_write_in && hit) begin
          if (avs_byteenable_in[0]) begin
            s_next.ctrl[7:0] = avs_writedata_in[7:0];
          end
          if (avs_byteenable_in[1]) begin
            s_next.ctrl[15:8] = avs_writedata_in[15:8];
          end
        end
      end
      default: begin
        // an illegal code falls back to idle with the bus stalled
        s_next.bus      = tpoc_pkg::BUS_IDLE;
        s_next.wait_req = 1'b1;
      end
    endcase
    // software standby has no input here, so it cannot touch ctrl
    if (hw_standby_in) begin
      s_next.ctrl = tpoc_pkg::CTRL_RESET;
      s_next.pins = tpoc_pkg::PINS_RESET[PIN_COUNT-1:0];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // single state register; reset takes constants only
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_out    = s_reg.rdata;
  assign avs_waitrequest_out = s_reg.wait_req;
  assign pulse_out           = s_reg.pins;

  // ****************************************
  // assertions
  // ****************************************
  // helper terms, so that every sampled past enable term below is a plain signal
  logic [PIN_COUNT-1:0] any_en;
  logic [PIN_COUNT-1:0] both_en;
  logic [PIN_COUNT-1:0] rise_set;
  logic [PIN_COUNT-1:0] fall_clr;
  assign any_en   = high_en | low_en;
  assign both_en  = high_en & low_en;
  assign rise_set = high_en & {PIN_COUNT{rise_match_in}};
  assign fall_clr = low_en & {PIN_COUNT{fall_match_in}};

  sequence seq_req_idle;
    req && s_reg.bus == tpoc_pkg::BUS_IDLE;
  endsequence

  sequence seq_wait_then_go;
    avs_waitrequest_out [*3] ##1 !avs_waitrequest_out;
  endsequence

  chk_access_four_cycles: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    seq_req_idle |-> seq_wait_then_go)
    else $error("register access did not take four cycles");

  chk_write_lands: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    avs_write_in && !avs_waitrequest_out && hit && !hw_standby_in
      && avs_byteenable_in[1:0] == 2'h3
    |=> s_reg.ctrl == $past(avs_writedata_in[15:0]))
    else $error("halfword write did not reach the enable register");

  chk_read_shows: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    avs_read_in && !avs_waitrequest_out && hit
    |-> avs_readdata_out == {16'h0000, s_reg.ctrl})
    else $error("read data differ from the enable register");

  chk_unmapped_zero: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    avs_read_in && !avs_waitrequest_out && !hit
    |-> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  chk_standby_clear: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    hw_standby_in |=> s_reg.ctrl == 16'h0000 && pulse_out == '0)
    else $error("hardware standby left state set");

  chk_rise_drives_high: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    rise_match_in && !fall_match_in && !hw_standby_in
    |=> (pulse_out & $past(high_en)) == $past(high_en))
    else $error("rise strobe did not drive enabled pins high");

  chk_fall_drives_low: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    fall_match_in |=> (pulse_out & $past(low_en)) == '0)
    else $error("fall strobe did not drive enabled pins low");

  chk_tie_goes_low: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    rise_match_in && fall_match_in
    |=> (pulse_out & $past(both_en)) == '0)
    else $error("tie between strobes did not give low");

  chk_hold_levels: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !rise_match_in && !fall_match_in && !hw_standby_in |=> $stable(pulse_out))
    else $error("pin moved without a compare strobe");

  chk_untouched_pins: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !hw_standby_in
    |=> ((pulse_out ^ $past(pulse_out)) & ~$past(any_en)) == '0)
    else $error("pin without enables changed level");

  // a write completes where the master samples waitrequest low
  sequence seq_write_taken;
    avs_write_in && !avs_waitrequest_out && hit && !hw_standby_in;
  endsequence

  // reset leaves the bus stalled, the register clear and every pin low
  chk_reset_values: assert property (
    @(posedge clk_sys_in)
    reset_in |=> avs_waitrequest_out && avs_readdata_out == tpoc_pkg::RDATA_RESET
      && s_reg.ctrl == tpoc_pkg::CTRL_RESET && pulse_out == '0)
    else $error("reset left the block in a busy or set state");

  // byte writes touch only their own half of the enable register
  chk_low_byte_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    seq_write_taken ##0 (avs_byteenable_in[1:0] == 2'h1)
    |=> s_reg.ctrl == {$past(s_reg.ctrl[15:8]), $past(avs_writedata_in[7:0])})
    else $error("low byte write disturbed the enable register");

  chk_high_byte_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    seq_write_taken ##0 (avs_byteenable_in[1:0] == 2'h2)
    |=> s_reg.ctrl == {$past(avs_writedata_in[15:8]), $past(s_reg.ctrl[7:0])})
    else $error("high byte write disturbed the enable register");

  chk_unmapped_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    avs_write_in && !avs_waitrequest_out && !hit && !hw_standby_in
    |=> $stable(s_reg.ctrl))
    else $error("write to another address changed the enable register");

  // nothing but a completed write, reset or hardware standby may change the enables
  chk_ctrl_kept: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !(avs_write_in && !avs_waitrequest_out) && !hw_standby_in
    |=> $stable(s_reg.ctrl))
    else $error("enable register changed without a write");

  // handshake shape: one answer cycle, never while idle, data held between
  chk_wait_one_cycle: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest stayed low for more than one cycle");

  chk_idle_stalls: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    s_reg.bus == tpoc_pkg::BUS_IDLE |-> avs_waitrequest_out)
    else $error("waitrequest low while no access was under way");

  chk_readdata_holds: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !(s_reg.bus == tpoc_pkg::BUS_COUNT && s_reg.cnt == tpoc_pkg::CNT_LAST)
    |=> $stable(avs_readdata_out))
    else $error("read data moved outside the answer cycle");

  // a pin may rise only on the rise strobe with its high enable set
  chk_rise_cause: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !hw_standby_in |=> (pulse_out & ~$past(pulse_out) & ~$past(rise_set)) == '0)
    else $error("pin rose without an enabled rise strobe");

  // away from standby a pin may fall only on the fall strobe with its low enable
  chk_fall_cause: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !hw_standby_in |=> (~pulse_out & $past(pulse_out) & ~$past(fall_clr)) == '0)
    else $error("pin fell without an enabled fall strobe");

endmodule : tpoc_ctrl

`default_nettype wire

// ---- tpoc_pkg.sv ----
// constants and types for the timed pulse output controller
// assumes a single 100 MHz system clock and an avalon-mm register slave
`default_nettype none
package tpoc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] CTRL_ADDR       = 32'hfffff700;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam int          HIGH_EN_LSB     = 0;
  localparam int          LOW_EN_LSB      = 8;
  localparam int          MAX_PINS        = 8;

  // ****************************************
  // bus timing and reset values
  // ****************************************
  localparam int          ACCESS_CYCLES   = 4;
  localparam int          CNT_W           = 3;
  localparam logic [2:0]  CNT_FIRST       = 3'h1;
  localparam logic [2:0]  CNT_LAST        = 3'(ACCESS_CYCLES - 2);
  localparam logic [7:0]  PINS_RESET      = 8'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

  // ****************************************
  // bus handshake states
  // ****************************************
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_COUNT,
    BUS_ANSWER
  } tpoc_bus_type;

endpackage : tpoc_pkg

`default_nettype wire

// ---- tpoc_timer_model.sv ----
// timer channel model: free-running count and two compare strobes
// assumes the bench sets both compare points while run_in is low
`timescale 1ns/1ns
`default_nettype none
module tpoc_timer_model (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // count control
  input  wire logic       run_in,
  input  wire logic [7:0] rise_cmp_in,
  input  wire logic [7:0] fall_cmp_in,
  // compare strobes
  output logic            rise_match_out,
  output logic            fall_match_out
);
  logic [7:0] cnt_reg;
  // count only wraps on overflow, so each strobe lasts one cycle
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !run_in) begin
      cnt_reg        <= 8'h00;
      rise_match_out <= 1'b0;
      fall_match_out <= 1'b0;
    end else begin
      cnt_reg        <= cnt_reg + 8'h01;
      rise_match_out <= (cnt_reg == rise_cmp_in);
      fall_match_out <= (cnt_reg == fall_cmp_in);
    end
  end
endmodule : tpoc_timer_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the pulse output controller
// assumes eight pins and the timer model on the strobe side
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****
  // stimulus, reference and checks
  // ****
  localparam logic [31:0] CTRL = 32'hfffff700;
  logic        clk_sys_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic        stby       = 1'b0;
  logic        run        = 1'b0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [7:0]  rcmp       = 8'h00;
  logic [7:0]  fcmp       = 8'h00;
  logic [3:0]  be         = 4'h0;
  logic [31:0] addr       = 32'h0;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] rdata, got;
  logic        rise_m, fall_m, wreq;
  logic [7:0]  pins;
  logic [7:0]  exp_pins   = 8'h00;
  logic [15:0] shadow     = 16'h0000;
  logic [15:0] seed       = 16'hc26e;
  int          mismatches = 0;
  int          num_checks = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  tpoc_ctrl dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .hw_standby_in(stby),
    .rise_match_in(rise_m), .fall_match_in(fall_m), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .pulse_out(pins));
  tpoc_timer_model tmr_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .run_in(run),
    .rise_cmp_in(rcmp), .fall_cmp_in(fcmp), .rise_match_out(rise_m),
    .fall_match_out(fall_m));

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // low drive wins where both strobes reach a doubly enabled pin
  function automatic logic [7:0] next_pins(logic [7:0] p, logic [15:0] c, logic r, logic f);
    return (r ? p | c[7:0] : p) & ~(f ? c[15:8] : 8'h00);
  endfunction : next_pins

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_cycles(logic [31:0] e, logic [31:0] g);
    chk("access cycles", e, g);
  endtask : chk_cycles

  task automatic chk_data(logic [31:0] e, logic [31:0] g);
    chk("readdata", e, g);
  endtask : chk_data

  task automatic chk_pins(logic [7:0] e, logic [7:0] g);
    chk("pulse_out", {24'h0, e}, {24'h0, g});
  endtask : chk_pins

  // one avalon access; request held until waitrequest samples low
  task automatic bus(logic w, logic [31:0] a, logic [15:0] d, logic [3:0] b);
    int n;
    @(posedge clk_sys_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    be <= b;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    // a stalled slave counts as a mismatch and ends the run
    if (wreq !== 1'b0) begin
      mismatches++;
      print_verdict();
    end
    got = rdata;
    if (w && a[31:2] == CTRL[31:2] && b[0]) shadow[7:0] <= d[7:0];
    if (w && a[31:2] == CTRL[31:2] && b[1]) shadow[15:8] <= d[15:8];
    rd <= 1'b0;
    wr <= 1'b0;
    chk_cycles(32'(tpoc_pkg::ACCESS_CYCLES), 32'(n));
  endtask : bus

  task automatic rd_chk(logic [31:0] a);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk_data((a[31:2] == CTRL[31:2]) ? {16'h0000, shadow} : 32'h0, got);
  endtask : rd_chk

  task automatic timer(logic [7:0] r, logic [7:0] f, int cycles);
    @(posedge clk_sys_in);
    rcmp <= r;
    fcmp <= f;
    run <= 1'b1;
    repeat (cycles) @(posedge clk_sys_in);
    run <= 1'b0;
  endtask : timer

  // reference pins; reset and standby clear both pins and enables
  always @(posedge clk_sys_in) begin
    if (reset_in || stby) exp_pins <= 8'h00;
    else exp_pins <= next_pins(exp_pins, shadow, rise_m, fall_m);
    if (reset_in || stby) shadow <= 16'h0000;
  end

  // pins compared every cycle out of reset, away from the launching edge
  always @(negedge clk_sys_in) begin
    if (!reset_in) chk_pins(exp_pins, pins);
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_chk(CTRL);
    bus(1'b1, CTRL, 16'h0101, 4'h3);
    timer(8'h0a, 8'h14, 40);
    bus(1'b1, CTRL, 16'hab55, 4'h2);
    rd_chk(CTRL);
    bus(1'b1, CTRL + 32'h4, 16'hffff, 4'h3);
    rd_chk(CTRL + 32'h4);
    bus(1'b1, CTRL, 16'h00ff, 4'h1);
    timer(8'h03, 8'hc8, 10);
    bus(1'b1, CTRL, 16'hffff, 4'h3);
    timer(8'h05, 8'h05, 10);
    bus(1'b1, CTRL, 16'he0e0, 4'h3);
    timer(8'h02, 8'hf0, 10);
    stby <= 1'b1;
    @(posedge clk_sys_in);
    stby <= 1'b0;
    rd_chk(CTRL);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      bus(1'b1, CTRL, seed, (seed[1:0] == 2'b00) ? 4'h3 : {2'b00, seed[1:0]});
      rd_chk(CTRL);
      seed = lfsr(seed);
      timer(seed[7:0], seed[15:8], 260);
    end
    // a reset in mid-run must clear the enables again
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_chk(CTRL);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
